// [core/sar_convert.sv]
// converter control, sample hold, successive approximation and readout
// assumes rst comes from the power-on-reset circuit, sck from the host,
// and the analog front end presents its level as an 18-bit code
//
// Behaviour
// - convert_start rising edge powers the core and starts converting.
// - start edges during a conversion are ignored.
// - busy is high throughout a conversion, low afterwards.
// - after conversion core powers down and tracks input again.
// - conversion finishes within 412 ns on the internal timing.
// - power-on reset clears state, then converter reinitialises.
// - previous result stays readable while powered down.
// - bits shift out only when enabled and shift clock pulses.
// - bits change on rising shift edge; host samples after.
// - top_result_bit holds until first rising shift edge.
// - normal mode: read select high floats output, low drives it.
// - normal mode, select low: new msb presented when busy falls.
// - normal mode: select falling presents stored msb at once.
// - chain mode: output always driven, select pin is data input.
// - chain mode: upstream msb appears after 18 shift edges.
// - chain mode: input sampled on each rising shift edge.
// - data leaves most significant bit first, one per edge.
// - result is straight unsigned binary.
`timescale 1ns/1ps
module sar_convert (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sck,
  input wire logic convert_start,
  input wire logic read_select_or_chain_input,
  input wire logic chain_select,
  input wire logic [17:0] sample_level,
  output logic busy,
  output logic core_power_on,
  output logic acquire_track,
  output logic sdo_out,
  output logic sdo_oe_n
);

  // pin synchronisers
  logic start_m_q;
  logic start_s_q;
  logic start_p_q;
  logic rsel_m_q;
  logic rsel_s_q;
  logic rsel_p_q;
  logic chain_m_q;
  logic chain_s_q;
  logic [17:0] level_m_q;
  logic [17:0] level_s_q;

  // converter state
  sar_pkg::sar_state_t state_q;
  logic [9:0] por_cnt_q;
  logic [3:0] cyc_q;
  logic [17:0] held_q;
  logic [17:0] code_q;
  logic [17:0] mask_q;
  logic [17:0] result_q;
  logic busy_q;
  logic restart_q;
  logic oe_n_q;

  // combinational helpers
  logic start_rise;
  logic rsel_fall;
  logic conv_done;
  logic [17:0] trial_hi;
  logic [17:0] base_code;
  logic [17:0] trial_lo;
  logic [17:0] code_d;

  // two-flop synchronisers for control pins
  always_ff @(posedge clk_sys) begin
    start_m_q <= convert_start;
    start_s_q <= start_m_q;
    rsel_m_q <= read_select_or_chain_input;
    rsel_s_q <= rsel_m_q;
    chain_m_q <= chain_select;
    chain_s_q <= chain_m_q;
  end

  // per-bit synchronisers for the front-end level
  genvar gi;
  generate
    for (gi = 0; gi < sar_pkg::RES_W; gi++) begin : g_lvl
      always_ff @(posedge clk_sys) begin
        level_m_q[gi] <= sample_level[gi];
        level_s_q[gi] <= level_m_q[gi];
      end
    end
  endgenerate

  // previous values for edge detection, taken after synchronisation
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_p_q <= 1'b0;
      rsel_p_q <= 1'b1;
    end else begin
      start_p_q <= start_s_q;
      rsel_p_q <= rsel_s_q;
    end
  end

  assign start_rise = start_s_q & ~start_p_q;
  // select falling only counts in normal mode
  assign rsel_fall = rsel_p_q & ~rsel_s_q & ~chain_s_q;
  assign conv_done = (state_q == sar_pkg::SAR_ST_CONV) &&
                     (cyc_q == sar_pkg::CONV_LAST);

  // reinitialisation counter after power-on reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      por_cnt_q <= sar_pkg::POR_CNT_RST;
    end else if (state_q == sar_pkg::SAR_ST_INIT) begin
      por_cnt_q <= por_cnt_q + 10'h001;
    end
  end

  // phase sequencing: init, acquire, convert
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= sar_pkg::SAR_ST_INIT;
    end else begin
      unique case (state_q)
        sar_pkg::SAR_ST_INIT: begin
          if (por_cnt_q == sar_pkg::POR_LAST) begin
            state_q <= sar_pkg::SAR_ST_ACQ;
          end
        end
        sar_pkg::SAR_ST_ACQ: begin
          if (start_rise) begin
            state_q <= sar_pkg::SAR_ST_CONV;
          end
        end
        sar_pkg::SAR_ST_CONV: begin
          // start edges fall through here unheeded
          if (conv_done) begin
            state_q <= sar_pkg::SAR_ST_ACQ;
          end
        end
        // the unused code falls back to init; the wait counter carries on from its old value
        default: begin
          state_q <= sar_pkg::SAR_ST_INIT;
        end
      endcase
    end
  end

  // cycle count within a conversion, fixed length from internal timing
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cyc_q <= sar_pkg::CNT_RST;
    end else if (state_q == sar_pkg::SAR_ST_CONV) begin
      cyc_q <= cyc_q + 4'h1;
    end else begin
      cyc_q <= sar_pkg::CNT_RST;
    end
  end

  // hold the sample at the start edge; tracks freely while acquiring
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      held_q <= sar_pkg::RESULT_RST;
    end else if (state_q == sar_pkg::SAR_ST_ACQ) begin
      held_q <= level_s_q;
    end
  end

  // two trial comparisons per step, top bit first, unsigned binary
  always_comb begin
    trial_hi = code_q | mask_q;
    base_code = (held_q >= trial_hi) ? trial_hi : code_q;
    trial_lo = base_code | {1'b0, mask_q[17:1]};
    code_d = (held_q >= trial_lo) ? trial_lo : base_code;
  end

  // approximation register and its bit mask
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      code_q <= sar_pkg::RESULT_RST;
      mask_q <= sar_pkg::MASK_TOP;
    end else if (state_q != sar_pkg::SAR_ST_CONV) begin
      code_q <= sar_pkg::RESULT_RST;
      mask_q <= sar_pkg::MASK_TOP;
    end else if (cyc_q <= sar_pkg::STEP_LAST) begin
      code_q <= code_d;
      mask_q <= {2'b00, mask_q[17:2]};
    end
  end

  // result register changes only at completion and survives power down
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_q <= sar_pkg::RESULT_RST;
    end else if (conv_done) begin
      result_q <= code_q;
    end
  end

  // busy and core power follow the conversion phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (state_q == sar_pkg::SAR_ST_ACQ && start_rise) begin
      busy_q <= 1'b1;
    end else if (conv_done) begin
      busy_q <= 1'b0;
    end
  end

  // restart the link frame: reset, new result, or select going low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      restart_q <= 1'b1;
    end else begin
      restart_q <= conv_done | rsel_fall;
    end
  end

  // output driver enable, low while driving
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oe_n_q <= 1'b1;
    end else if (chain_s_q) begin
      oe_n_q <= 1'b0;
    end else begin
      oe_n_q <= rsel_s_q;
    end
  end

  // shift-clock side of the readout
  sar_link_shift u_link (
    .sck(sck),
    .restart(restart_q),
    .sdi(read_select_or_chain_input),
    .result(result_q),
    .sdo_bit(sdo_out)
  );

  assign busy = busy_q;
  assign core_power_on = busy_q;
  assign acquire_track = ~busy_q & (state_q == sar_pkg::SAR_ST_ACQ);
  assign sdo_oe_n = oe_n_q;

endmodule : sar_convert

// [core/sar_pkg.sv]
// constants and types shared by the converter control and its serial link
// assumes a 25 MHz system clock; the link side runs on the host shift clock
package sar_pkg;

  // result width and derived sizes
  localparam int RES_W = 18;
  localparam int POS_W = 5;
  localparam logic [POS_W-1:0] POS_LAST = 5'h12; // 18 shifts
  localparam logic [POS_W-1:0] POS_RST = 5'h00;

  // system clock period
  localparam int CLK_NS = 40;

  // longest conversion time, rounded down to whole cycles
  localparam int CONV_TIME_NS = 412;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_NS;
  localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);

  // successive approximation resolves two bits per step
  localparam int SAR_STEPS = RES_W / 2;
  localparam logic [3:0] STEP_LAST = 4'(SAR_STEPS - 1);

  // reinitialisation time after a power-on reset, rounded up
  localparam int POR_WAIT_US = 20;
  localparam int POR_WAIT_CYCLES = (POR_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0] POR_LAST = 10'(POR_WAIT_CYCLES - 1);

  // values after reset
  localparam logic [RES_W-1:0] RESULT_RST = 18'h00000;
  localparam logic [RES_W-1:0] MASK_TOP = 18'h20000;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [9:0] POR_CNT_RST = 10'h000;

  // converter phases
  typedef enum logic [1:0] {
    SAR_ST_INIT,
    SAR_ST_ACQ,
    SAR_ST_CONV
  } sar_state_t;

endpackage : sar_pkg

// [core/sar_link_shift.sv]
// shift-clock side of the serial readout: bit position and chain capture
// assumes result is held steady by the converter while the host clocks
`timescale 1ns/1ps
module sar_link_shift (
  input wire logic sck,
  input wire logic restart,
  input wire logic sdi,
  input wire logic [17:0] result,
  output logic sdo_bit
);

  logic [sar_pkg::POS_W-1:0] pos_q;
  logic [sar_pkg::RES_W-1:0] chain_q;
  logic [sar_pkg::POS_W-1:0] idx;

  // position advances one per rising shift edge and holds at 18; restart comes from the
  // system domain so a new frame begins with no shift edge needed
  always_ff @(posedge sck or posedge restart) begin
    if (restart) begin
      pos_q <= sar_pkg::POS_RST;
    end else if (pos_q != sar_pkg::POS_LAST) begin
      pos_q <= pos_q + 5'h01;
    end
  end

  // upstream data sampled on every rising edge, first edge takes its msb
  always_ff @(posedge sck) begin
    chain_q <= {chain_q[16:0], sdi};
  end

  // own result msb first, then upstream bits after 18 edges
  assign idx = 5'h11 - pos_q;
  assign sdo_bit = (pos_q < sar_pkg::POS_LAST) ? result[idx]
                                               : chain_q[17];

endmodule : sar_link_shift

// [bench/sar_chk.sv]
// assertions on the converter control ports
// assumes a bind onto sar_convert, clk_sys domain only
`timescale 1ns/1ps
module sar_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic convert_start,
  input wire logic read_select_or_chain_input,
  input wire logic chain_select,
  input wire logic busy,
  input wire logic core_power_on,
  input wire logic acquire_track,
  input wire logic sdo_oe_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // conversion phase: busy length, power and tracking
  property p_len;
    $rose(busy) |-> busy [*5] ##1 busy [*5] ##1 !busy;
  endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_pwr;
    (core_power_on == busy) and
      ($rose(core_power_on) |-> $past(acquire_track));
  endproperty
  a_pwr: assert property (p_pwr) else $error("power state");
  property p_trk;
    (busy |-> !acquire_track) and ($fell(busy) |-> acquire_track);
  endproperty
  a_trk: assert property (p_trk) else $error("tracking");
  property p_go;
    $rose(convert_start) && acquire_track |-> ##[1:6] busy;
  endproperty
  a_go: assert property (p_go) else $error("start missed");
  // output enable in both modes
  property p_hiz;
    (!chain_select && read_select_or_chain_input) [*6] |-> sdo_oe_n;
  endproperty
  a_hiz: assert property (p_hiz) else $error("not floated");
  property p_drv;
    (!chain_select && !read_select_or_chain_input) [*6] |-> !sdo_oe_n;
  endproperty
  a_drv: assert property (p_drv) else $error("not driven");
  property p_chn;
    chain_select [*6] |-> !sdo_oe_n;
  endproperty
  a_chn: assert property (p_chn) else $error("chain drive");
  // reset values, seen even while reset holds
  property p_rst;
    disable iff (1'b0) rst |=> !busy && sdo_oe_n && !acquire_track;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
endmodule : sar_chk

bind sar_convert sar_chk i_chk (.clk_sys(clk_sys), .rst(rst),
  .convert_start(convert_start),
  .read_select_or_chain_input(read_select_or_chain_input),
  .chain_select(chain_select), .busy(busy), .core_power_on(core_power_on),
  .acquire_track(acquire_track), .sdo_oe_n(sdo_oe_n));

// [bench/sar_host.sv]
// host model: convert strobe, shift clock, select or chain data
// assumes 12 ns shift clock inside frames, held low between them
`timescale 1ns/1ps
module sar_host (
  input wire logic clk_sys,
  input wire logic chain_select,
  input wire logic sdo_out,
  output logic convert_start,
  output logic sck,
  output logic sel
);
  // idle levels: select high, shift clock still
  initial begin
    convert_start = 1'b0;
    sck = 1'b0;
    sel = 1'b1;
  end
  // one start pulse after the acquisition gap, low again within 40 ns
  task automatic start_conv();
    repeat (6) @(posedge clk_sys);
    convert_start <= 1'b1;
    @(posedge clk_sys);
    convert_start <= 1'b0;
  endtask : start_conv
  task automatic set_sel(input logic v);
    @(posedge clk_sys);
    sel <= v;
  endtask : set_sel
  // n bits msb first; chain data set up ahead of each rising edge
  task automatic shift(input int n, input logic [35:0] up,
    output logic [35:0] got);
    got = 36'h000000000;
    repeat (3) @(posedge clk_sys); // read once busy has fallen
    for (int i = n - 1; i >= 0; i--) begin
      if (chain_select) begin
        sel = up[i];
      end
      #6;
      got[i] = sdo_out;
      sck = 1'b1;
      #6;
      sck = 1'b0;
    end
  endtask : shift
endmodule : sar_host

// [bench/tb_sar_convert.sv]
// testbench: conversions with normal and chain readout of sar_convert
// assumes the host model owns the strobe, shift clock and select pin
`timescale 1ns/1ps
module tb_sar_convert;
  logic clk_sys, rst, chain_select, convert_start, sck, sel;
  logic busy, core_power_on, acquire_track, sdo_out, sdo_oe_n;
  logic [17:0] sample_level;
  logic [35:0] got;
  int n_mismatch, n_compared;

  sar_convert i_dut (.clk_sys(clk_sys), .rst(rst), .sck(sck),
    .convert_start(convert_start), .read_select_or_chain_input(sel),
    .chain_select(chain_select), .sample_level(sample_level),
    .busy(busy), .core_power_on(core_power_on),
    .acquire_track(acquire_track), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));
  sar_host i_host (.clk_sys(clk_sys), .chain_select(chain_select),
    .sdo_out(sdo_out), .convert_start(convert_start), .sck(sck), .sel(sel));

  // system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(input string what, input logic [35:0] e,
    input logic [35:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", what, e, s);
    end
  endtask : cmp
  // bounded wait for busy to reach a level, sampled at falling edges
  task automatic wait_busy(input logic v);
    int k = 0;
    while (busy !== v && k < 100) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 100) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wait_busy
  // reset values, then the power-on wait
  task automatic t_reset();
    @(negedge clk_sys);
    cmp("busy", 36'h0, busy);
    cmp("track", 36'h0, acquire_track);
    cmp("oe_n", 36'h1, sdo_oe_n);
    repeat (510) @(negedge clk_sys);
    cmp("track", 36'h1, acquire_track);
  endtask : t_reset
  // one conversion; the level moves after completion
  task automatic t_conv(input logic [17:0] lv);
    @(posedge clk_sys);
    sample_level <= lv;
    i_host.start_conv();
    wait_busy(1'b1);
    cmp("power", 36'h1, core_power_on);
    cmp("track", 36'h0, acquire_track);
    wait_busy(1'b0);
    @(negedge clk_sys);
    cmp("track", 36'h1, acquire_track);
    cmp("power", 36'h0, core_power_on);
    @(posedge clk_sys);
    sample_level <= ~lv;
  endtask : t_conv
  task automatic t_normal(input logic [17:0] lv);
    t_conv(lv);
    i_host.shift(18, 36'h0, got);
    cmp("frame", {18'h00000, lv}, got);
  endtask : t_normal
  // deselect, then reselect and read the held result again
  task automatic t_reselect(input logic [17:0] lv);
    i_host.set_sel(1'b1);
    repeat (8) @(negedge clk_sys);
    cmp("oe_n", 36'h1, sdo_oe_n);
    i_host.set_sel(1'b0);
    repeat (8) @(negedge clk_sys);
    cmp("msb", lv[17], sdo_out);
    i_host.shift(18, 36'h0, got);
    cmp("frame", {18'h00000, lv}, got);
  endtask : t_reselect
  // chain mode: own result, then upstream data 18 edges later
  task automatic t_chain(input logic [17:0] lv, input logic [17:0] up);
    // select high first, so only chain mode can enable the driver
    i_host.set_sel(1'b1);
    @(posedge clk_sys);
    chain_select <= 1'b1;
    repeat (8) @(negedge clk_sys);
    cmp("oe_n", 36'h0, sdo_oe_n);
    t_conv(lv);
    i_host.shift(36, {up, 18'h00000}, got);
    cmp("chain", {lv, up}, got);
  endtask : t_chain
  // second power-on reset in mid-run clears the held result
  task automatic t_por();
    i_host.set_sel(1'b1);
    rst <= 1'b1;
    chain_select <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    i_host.set_sel(1'b0);
    repeat (8) @(negedge clk_sys);
    cmp("msb", 36'h0, sdo_out);
    i_host.shift(18, 36'h0, got);
    cmp("frame", 36'h0, got);
  endtask : t_por
  // main sequence
  initial begin
    rst = 1'b1;
    chain_select = 1'b0;
    sample_level = 18'h00000;
    n_mismatch = 0;
    n_compared = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    i_host.set_sel(1'b0);
    t_normal(18'h3FFFF);
    t_normal(18'h00000);
    t_normal(18'h2A5A5);
    t_reselect(18'h2A5A5);
    t_chain(18'h15A5A, 18'h3C0F3);
    t_por();
    complete_run();
  end
endmodule : tb_sar_convert
